// file: rtl/switch_cfg_regs.svh
/*
  Register map, field positions, reset values and timing figures of the
  switch and configuration register bank.
  Assumes it is included by bare name from rtl/ files only.
*/
`ifndef SWITCH_CFG_REGS_SVH
`define SWITCH_CFG_REGS_SVH

// Subaddresses seen over the two-wire register port
`define SUB_UNLOCK    8'h10
`define SUB_SWITCH    8'h12
`define SUB_SUPERV    8'h13
`define SUB_PINLIM    8'h14

// Reset values and writable-bit masks (reserved bits masked off)
`define RST_SWITCH    8'h00
`define RST_SUPERV    8'h08
`define RST_PINLIM    8'h40
`define MASK_SWITCH   8'h7f
`define MASK_SUPERV   8'hff
`define MASK_PINLIM   8'hcf
`define READ_NONE     8'h00

// Unlock key: target subaddress xor this value (arbitrary value)
`define UNLOCK_XOR    8'h5a
// Own 7-bit bus address on the register port (arbitrary value)
`define DEV_ADDR      7'h30
`define BITS_PER_BYTE 4'h8

// Output switch enable fields
`define B_GEN_REG     0
`define B_LOW_SW      1
`define B_FIVE_SW     2
`define B_HIGH_SW     3
`define B_FIRST_OUT   4
`define B_SECOND_OUT  5
`define B_RST_POL     6

// Supervisor setup fields
`define B_PB_TIME     7
`define B_BUF_TYPE    6
`define B_IO_SEL      5
`define POWER_GOOD_DELAY_FIELD_HI      4
`define POWER_GOOD_DELAY_FIELD_LO      3
`define B_STRICTNESS_BIT      2
`define UNDERVOLTAGE_LOCKOUT_FIELD_HI       1
`define UNDERVOLTAGE_LOCKOUT_FIELD_LO       0

// Pin and limit setup fields
`define B_WARM_SEL    7
`define B_UNDERVOLTAGE_LOCKOUT_FIELD_HYS    6
`define HV_ILIM_HI    3
`define HV_ILIM_LO    2
`define FV_ILIM_HI    1
`define FV_ILIM_LO    0

// Timing figures in their own units
`define CLK_HZ        64'h0000_0000_0ee6_b280
`define MS_PER_S      64'h3e8
`define PB_SHORT_S    64'h8
`define PB_LONG_S     64'hf
`define PGDLY0_MS     64'ha
`define PGDLY1_MS     64'h14
`define PGDLY2_MS     64'h32
`define PGDLY3_MS     64'h96

`define SYNC_W        6

`endif

// file: rtl/switch_cfg_pkg.sv
/*
  Types shared by the register bank, its synchroniser and its timers.
  Assumes switch_cfg_regs.svh is on the include path.
*/
`include "switch_cfg_regs.svh"
package switch_cfg_pkg;
  // Register-port byte engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } port_state_t;

  // Whole state of the register bank
  typedef struct packed {
    port_state_t st;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic [7:0]  ptr;
    logic        rw;
    logic        sda_oe;
    logic [7:0]  rd_byte;
    logic        unlock_vld;
    logic [7:0]  unlock_key;
    logic [7:0]  sw_reg;
    logic [7:0]  sup_reg;
    logic [7:0]  pin_reg;
    logic        scl_d;
    logic        sda_d;
    logic        rst_pol_oe;
    logic        first_oe;
    logic        second_o;
    logic        second_oe;
    logic        warm_rst;
  } bank_state_t;

  // Hold timer state
  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } timer_state_t;

  // Two-stage synchroniser state
  typedef struct packed {
    logic [`SYNC_W-1:0] stage1;
    logic [`SYNC_W-1:0] stage2;
  } sync_state_t;
endpackage

// file: rtl/hold_timer_if.sv
/*
  Carrier between the register bank and a hold timer.
  Assumes both ends share the bank clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface hold_timer_if;
  logic        arm;    // Condition being timed
  logic [31:0] limit;  // Cycles it must hold
  logic        done;   // Held long enough
  modport owner (output arm, output limit, input done);
  modport timer (input arm, input limit, output done);
endinterface
`default_nettype wire

// file: rtl/pin_sync.sv
/*
  Two-flop synchroniser for every pin input of the bank.
  Assumes a clean, already synchronised active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import switch_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Pins in, levels out
  input  wire logic [`SYNC_W-1:0] raw,
  output var  logic [`SYNC_W-1:0] synced
);
  sync_state_t state_ff;   // Both stages
  sync_state_t nxt_state;  // Next stages

  // First stage feeds only the second
  always_comb
  begin
    nxt_state.stage1 = raw;
    nxt_state.stage2 = state_ff.stage1;
  end

  // Idle-high bus pins reset high to avoid a false start
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= '1;
    else
      state_ff <= nxt_state;
  end

  assign synced = state_ff.stage2;
endmodule
`default_nettype wire

// file: rtl/hold_timer.sv
/*
  Counts how long a condition has held and flags it once the limit
  is reached; dropping the condition clears the flag at once.
  Assumes arm is already on this clock.
*/
`timescale 1ns/1ns
`default_nettype none
module hold_timer
  import switch_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Timed condition
  hold_timer_if.timer tif
);
  timer_state_t state_ff;   // Count and flag
  timer_state_t nxt_state;  // Next count and flag

  // Saturating count while armed
  always_comb
  begin
    nxt_state = state_ff;
    if (!tif.arm)
    begin
      nxt_state.cnt  = '0;
      nxt_state.done = 1'b0;
    end
    else if (state_ff.cnt < tif.limit)
    begin
      nxt_state.cnt = 32'(state_ff.cnt + 32'h1);
    end
    nxt_state.done = tif.arm && (nxt_state.cnt >= tif.limit);
  end

  // Single state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign tif.done = state_ff.done;
endmodule
`default_nettype wire

// file: rtl/switch_cfg_bank.sv
/*
  Password-protected switch enable, supervisor setup and pin/limit
  setup registers behind a two-wire register port, with the pin
  drivers, push-button hold timer and power-good delay they control.
  Assumes pins are outside the clock domain; the sequencer update
  inputs come from logic on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module switch_cfg_bank
  import switch_cfg_pkg::*;
#(
  parameter logic [31:0] PB_SHORT_CYC = 32'(`PB_SHORT_S * `CLK_HZ),
  parameter logic [31:0] PB_LONG_CYC  = 32'(`PB_LONG_S * `CLK_HZ),
  parameter logic [31:0] PG_DLY0_CYC  =
    32'(`PGDLY0_MS * `CLK_HZ / `MS_PER_S),
  parameter logic [31:0] PG_DLY1_CYC  =
    32'(`PGDLY1_MS * `CLK_HZ / `MS_PER_S),
  parameter logic [31:0] PG_DLY2_CYC  =
    32'(`PGDLY2_MS * `CLK_HZ / `MS_PER_S),
  parameter logic [31:0] PG_DLY3_CYC  =
    32'(`PGDLY3_MS * `CLK_HZ / `MS_PER_S)
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Two-wire register port
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Reset polarity pin, open-drain or warm-reset input
  input  wire logic       reset_polarity_pin_i,
  output logic            reset_polarity_pin_o,
  output logic            reset_polarity_pin_oe,
  // First general pin, open-drain output or control input
  input  wire logic       first_general_pin_i,
  output logic            first_general_pin_o,
  output logic            first_general_pin_oe,
  // Second general output
  output logic            second_general_output_o,
  output logic            second_general_output_oe,
  // Sequencer update of low-voltage switch and regulator bits
  input  wire logic       seq_update,
  input  wire logic       seq_low_voltage_switch_en,
  input  wire logic       seq_general_regulator_en,
  // Push-button and raw power-good pins
  input  wire logic       push_button_b,
  input  wire logic       power_good_raw,
  // Switch and regulator enables
  output logic            high_voltage_switch_enable,
  output logic            five_volt_switch_enable,
  output logic            low_voltage_switch_enable,
  output logic            general_regulator_enable,
  // Supervisor controls
  output logic            push_button_reset,
  output logic            power_good,
  output logic            strictness_bit_limits,
  output logic            overvoltage_monitor_en,
  output logic [1:0]      undervoltage_lockout_field,
  output logic            undervoltage_hysteresis,
  // Warm reset request to both core bucks
  output logic            core_buck_warm_reset,
  // Current limit codes
  output logic [1:0]      high_voltage_switch_current_limit,
  output logic [1:0]      five_volt_switch_current_limit
);
  bank_state_t        state_ff;     // All bank state
  bank_state_t        nxt_state;    // Next bank state
  logic [1:0]         rst_sync_ff;  // Reset release stages
  logic               rst_n;        // Synchronised reset
  logic [`SYNC_W-1:0] pin_raw;      // Pins before sync
  logic [`SYNC_W-1:0] pin_s;        // Pins after sync
  logic               scl_s;        // Synced clock line
  logic               sda_s;        // Synced data line
  logic               rst_pol_s;    // Synced reset pin
  logic               first_s;      // Synced first pin
  logic               pb_s;         // Synced push-button
  logic               pg_s;         // Synced power-good
  logic               scl_rise;     // Clock line rose
  logic               scl_fall;     // Clock line fell
  logic               bus_start;    // Start condition
  logic               bus_stop;     // Stop condition
  logic               drive_lvl;    // Second output level
  logic [7:0]         rd_val;       // Read-back at the pointer
  hold_timer_if       pb_if ();     // Push-button timer link
  hold_timer_if       pg_if ();     // Power-good timer link

  // Read-back of one subaddress; unmapped and unlock read zero
  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input bank_state_t s);
    case (a)
      `SUB_SWITCH: read_reg = s.sw_reg & `MASK_SWITCH;
      `SUB_SUPERV: read_reg = s.sup_reg & `MASK_SUPERV;
      `SUB_PINLIM: read_reg = s.pin_reg & `MASK_PINLIM;
      default:     read_reg = `READ_NONE;
    endcase
  endfunction

  // Power-good delay in cycles for a field code
  function automatic logic [31:0] pg_cycles(input logic [1:0] code);
    case (code)
      2'h0:    pg_cycles = PG_DLY0_CYC;
      2'h1:    pg_cycles = PG_DLY1_CYC;
      2'h2:    pg_cycles = PG_DLY2_CYC;
      default: pg_cycles = PG_DLY3_CYC;
    endcase
  endfunction

  // Named copy, since a function result cannot be bit-selected
  assign rd_val = read_reg(state_ff.ptr, state_ff);

  // Reset is released through two flops, asserted at once
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Every pin crosses two flops before use
  assign pin_raw = {power_good_raw, push_button_b, first_general_pin_i,
                    reset_polarity_pin_i, sda_i, scl_i};

  pin_sync u_sync (
    .clk    (ref_clk),
    .rst_n  (rst_n),
    .raw    (pin_raw),
    .synced (pin_s)
  );

  assign scl_s     = pin_s[0];
  assign sda_s     = pin_s[1];
  assign rst_pol_s = pin_s[2];
  assign first_s   = pin_s[3];
  assign pb_s      = pin_s[4];
  assign pg_s      = pin_s[5];

  // Bus events from synced lines only
  assign scl_rise  = scl_s & ~state_ff.scl_d;
  assign scl_fall  = ~scl_s & state_ff.scl_d;
  assign bus_start = scl_s & state_ff.scl_d & state_ff.sda_d & ~sda_s;
  assign bus_stop  = scl_s & state_ff.scl_d & ~state_ff.sda_d & sda_s;

  // Push-button must be held 8 s or 15 s
  assign pb_if.arm   = ~pb_s;
  assign pb_if.limit = state_ff.sup_reg[`B_PB_TIME] ? PB_LONG_CYC
                                                    : PB_SHORT_CYC;

  hold_timer u_pb_timer (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .tif   (pb_if)
  );

  // Delay only the rise; a fall disarms the timer at once
  assign pg_if.arm   = pg_s;
  assign pg_if.limit =
    pg_cycles(state_ff.sup_reg[`POWER_GOOD_DELAY_FIELD_HI:`POWER_GOOD_DELAY_FIELD_LO]);

  hold_timer u_pg_timer (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .tif   (pg_if)
  );

  // Level the second output should show before buffer choice
  assign drive_lvl = state_ff.sup_reg[`B_IO_SEL] ? first_s
                                        : state_ff.sw_reg[`B_SECOND_OUT];

  // Byte engine, register writes and pin drive
  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.scl_d = scl_s;
    nxt_state.sda_d = sda_s;
    if (bus_start)
    begin
      // Start or repeated start always restarts address phase
      nxt_state.st     = ST_ADDR;
      nxt_state.cnt    = 4'h0;
      nxt_state.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      nxt_state.st     = ST_IDLE;
      nxt_state.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_ff.st)
        ST_ADDR, ST_SUB, ST_WDATA:
        begin
          nxt_state.shift = {state_ff.shift[6:0], sda_s};
          nxt_state.cnt   = 4'(state_ff.cnt + 4'h1);
        end
        ST_RACK:
        begin
          // Host not acknowledging ends the read burst
          if (sda_s)
            nxt_state.st = ST_IDLE;
        end
        default:
        begin
          nxt_state.st = state_ff.st;
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (state_ff.st)
        ST_ADDR:
        begin
          if (state_ff.cnt == `BITS_PER_BYTE)
          begin
            if (state_ff.shift[7:1] == `DEV_ADDR)
            begin
              nxt_state.st     = ST_ADDR_ACK;
              nxt_state.rw     = state_ff.shift[0];
              nxt_state.sda_oe = 1'b1;
            end
            else
              nxt_state.st = ST_IDLE;
          end
        end
        ST_SUB:
        begin
          if (state_ff.cnt == `BITS_PER_BYTE)
          begin
            nxt_state.ptr    = state_ff.shift;
            nxt_state.st     = ST_SUB_ACK;
            nxt_state.sda_oe = 1'b1;
          end
        end
        ST_WDATA:
        begin
          if (state_ff.cnt == `BITS_PER_BYTE)
          begin
            nxt_state.st     = ST_WACK;
            nxt_state.sda_oe = 1'b1;
            nxt_state.ptr    = 8'(state_ff.ptr + 8'h1);
            // Any data byte except an unlock spends the unlock
            nxt_state.unlock_vld = 1'b0;
            if (state_ff.ptr == `SUB_UNLOCK)
            begin
              nxt_state.unlock_vld = 1'b1;
              nxt_state.unlock_key = state_ff.shift;
            end
            else if (state_ff.unlock_vld &&
                     state_ff.unlock_key ==
                     (state_ff.ptr ^ `UNLOCK_XOR))
            begin
              case (state_ff.ptr)
                `SUB_SWITCH:
                  nxt_state.sw_reg = state_ff.shift & `MASK_SWITCH;
                `SUB_SUPERV:
                  nxt_state.sup_reg = state_ff.shift & `MASK_SUPERV;
                `SUB_PINLIM:
                  nxt_state.pin_reg = state_ff.shift & `MASK_PINLIM;
                default:
                  nxt_state.sw_reg = state_ff.sw_reg;
              endcase
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (state_ff.rw)
          begin
            // First read byte, MSB driven right away
            nxt_state.rd_byte = {rd_val[6:0], 1'b0};
            nxt_state.sda_oe  = ~rd_val[7];
            nxt_state.cnt     = 4'h1;
            nxt_state.st      = ST_RDATA;
          end
          else
          begin
            nxt_state.sda_oe = 1'b0;
            nxt_state.cnt    = 4'h0;
            nxt_state.st     = ST_SUB;
          end
        end
        ST_SUB_ACK, ST_WACK:
        begin
          nxt_state.sda_oe = 1'b0;
          nxt_state.cnt    = 4'h0;
          nxt_state.st     = ST_WDATA;
        end
        ST_RDATA:
        begin
          if (state_ff.cnt == `BITS_PER_BYTE)
          begin
            nxt_state.sda_oe = 1'b0;
            nxt_state.st     = ST_RACK;
            nxt_state.ptr    = 8'(state_ff.ptr + 8'h1);
          end
          else
          begin
            nxt_state.sda_oe  = ~state_ff.rd_byte[7];
            nxt_state.rd_byte = {state_ff.rd_byte[6:0], 1'b0};
            nxt_state.cnt     = 4'(state_ff.cnt + 4'h1);
          end
        end
        ST_RACK:
        begin
          // Host acknowledged: stream the next subaddress
          nxt_state.rd_byte = {rd_val[6:0], 1'b0};
          nxt_state.sda_oe  = ~rd_val[7];
          nxt_state.cnt     = 4'h1;
          nxt_state.st      = ST_RDATA;
        end
        default:
        begin
          nxt_state.st = ST_IDLE;
        end
      endcase
    end

    // Sequencer wins over a host write in the same cycle
    if (seq_update)
    begin
      nxt_state.sw_reg[`B_LOW_SW]  = seq_low_voltage_switch_en;
      nxt_state.sw_reg[`B_GEN_REG] = seq_general_regulator_en;
    end

    // Reset pin: open-drain low while bit is 0, input when selected
    nxt_state.rst_pol_oe = ~state_ff.pin_reg[`B_WARM_SEL] &
                           ~state_ff.sw_reg[`B_RST_POL];
    nxt_state.warm_rst   = state_ff.pin_reg[`B_WARM_SEL] &
                           ~rst_pol_s;
    // First pin: open-drain output, or released to act as input
    nxt_state.first_oe   = ~state_ff.sup_reg[`B_IO_SEL] &
                           ~state_ff.sw_reg[`B_FIRST_OUT];
    // Second output: push-pull drives both levels, open-drain only low
    if (state_ff.sup_reg[`B_BUF_TYPE])
    begin
      nxt_state.second_oe = 1'b1;
      nxt_state.second_o  = drive_lvl;
    end
    else
    begin
      nxt_state.second_oe = ~drive_lvl;
      nxt_state.second_o  = 1'b0;
    end
  end

  // One state register, reset to power-on values
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff         <= '0;
      state_ff.sw_reg  <= `RST_SWITCH;
      state_ff.sup_reg <= `RST_SUPERV;
      state_ff.pin_reg <= `RST_PINLIM;
      state_ff.scl_d   <= 1'b1;
      state_ff.sda_d   <= 1'b1;
    end
    else
      state_ff <= nxt_state;
  end

  // Register port drives only low
  assign sda_o  = 1'b0;
  assign sda_oe = state_ff.sda_oe;

  // Pin drivers
  assign reset_polarity_pin_o     = 1'b0;
  assign reset_polarity_pin_oe    = state_ff.rst_pol_oe;
  assign first_general_pin_o      = 1'b0;
  assign first_general_pin_oe     = state_ff.first_oe;
  assign second_general_output_o  = state_ff.second_o;
  assign second_general_output_oe = state_ff.second_oe;
  assign core_buck_warm_reset     = state_ff.warm_rst;

  // Enables straight from register bits
  assign high_voltage_switch_enable = state_ff.sw_reg[`B_HIGH_SW];
  assign five_volt_switch_enable    = state_ff.sw_reg[`B_FIVE_SW];
  assign low_voltage_switch_enable  = state_ff.sw_reg[`B_LOW_SW];
  assign general_regulator_enable   = state_ff.sw_reg[`B_GEN_REG];

  // Supervisor controls
  assign push_button_reset      = pb_if.done;
  assign power_good             = pg_if.done;
  assign strictness_bit_limits          = state_ff.sup_reg[`B_STRICTNESS_BIT];
  assign overvoltage_monitor_en = state_ff.sup_reg[`B_STRICTNESS_BIT];
  assign undervoltage_lockout_field =
    state_ff.sup_reg[`UNDERVOLTAGE_LOCKOUT_FIELD_HI:`UNDERVOLTAGE_LOCKOUT_FIELD_LO];
  assign undervoltage_hysteresis = state_ff.pin_reg[`B_UNDERVOLTAGE_LOCKOUT_FIELD_HYS];

  // Current limit codes
  assign high_voltage_switch_current_limit =
    state_ff.pin_reg[`HV_ILIM_HI:`HV_ILIM_LO];
  assign five_volt_switch_current_limit =
    state_ff.pin_reg[`FV_ILIM_HI:`FV_ILIM_LO];
endmodule
`default_nettype wire

// file: testbench/i2c_host.sv
/* Host model for the bank's two-wire register port.
   Assumes a pull-up on the data line and one shared clock. */
`timescale 1ns/1ns
`default_nettype none
module i2c_host (
  // Clock
  input  wire logic clk,
  // Bus wires
  input  wire logic dev_oe,
  output var  logic scl,
  output wire logic sda
);
  logic drv;                   // Host data drive, 1 releases
  assign sda = drv & ~dev_oe;  // Pull-up, either side pulls low
  initial {scl, drv} = 2'b11;
  // One bus phase; far above the bank's four-cycle minimum
  task automatic st(input logic c, input logic d);
    scl <= c;
    drv <= d;
    repeat (25) @(posedge clk);
  endtask
  // Start (s=1) or stop (s=0) condition
  task automatic cond(input logic s);
    st(1'b0, s);
    st(1'b1, s);
    st(1'b1, ~s);
  endtask
  // Byte MSB first, then a released ack slot; q collects the wire
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic [8:0] v;
    v = {d, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      st(1'b0, v[i]);
      st(1'b1, v[i]);
      if (i > 0)
        q[i-1] = sda;
    end
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    logic [7:0] q;
    cond(1'b1);
    xfer(8'h60, q);
    xfer(sub, q);
    xfer(d, q);
    cond(1'b0);
  endtask
  // Unlock immediately before the protected write
  task automatic pwr(input logic [7:0] sub, input logic [7:0] d);
    wr(8'h10, sub ^ 8'h5a);
    wr(sub, d);
  endtask
  // Single-byte read; the final ack slot stays released as a nack
  task automatic rd(input logic [7:0] sub, output logic [7:0] q);
    cond(1'b1);
    xfer(8'h60, q);
    xfer(sub, q);
    cond(1'b1);
    xfer(8'h61, q);
    xfer(8'hff, q);
    cond(1'b0);
  endtask
endmodule
`default_nettype wire

// file: testbench/switch_cfg_bank_asserts.sv
/* Port checker for the switch and configuration bank.
   Assumes it is bound to the bank with its shortened timers. */
`timescale 1ns/1ns
`default_nettype none
module switch_cfg_bank_asserts #(
  parameter logic [31:0] PB_SHORT_CYC = 32'h14,
  parameter logic [31:0] PG_DLY0_CYC  = 32'h5
) (
  // Clock, reset and pins
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic push_button_b,
  input wire logic power_good_raw,
  input wire logic reset_polarity_pin_i,
  // Bank outputs
  input wire logic reset_polarity_pin_oe,
  input wire logic push_button_reset,
  input wire logic power_good,
  input wire logic strictness_bit_limits,
  input wire logic overvoltage_monitor_en,
  input wire logic core_buck_warm_reset,
  input wire logic second_general_output_o,
  input wire logic second_general_output_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Shortest hold settings; raw pins lead the bank's synced copy
  property p_pb; $rose(push_button_reset) |->
    !$past(push_button_b, PB_SHORT_CYC); endproperty
  a_pb: assert property (p_pb) else $error("button reset early");
  property p_pb_off; $rose(push_button_b) |->
    ##5 !push_button_reset; endproperty
  a_pb_off: assert property (p_pb_off) else $error("button stuck");
  property p_pg; $rose(power_good) |->
    $past(power_good_raw, PG_DLY0_CYC); endproperty
  a_pg: assert property (p_pg) else $error("good rose early");
  property p_pg_fall; !power_good_raw [*5] |-> !power_good; endproperty
  a_pg_fall: assert property (p_pg_fall) else $error("good late");
  property p_strictness_bit; strictness_bit_limits == overvoltage_monitor_en; endproperty
  a_strictness_bit: assert property (p_strictness_bit) else $error("strictness_bit split");
  property p_warm; core_buck_warm_reset [*2] |->
    !reset_polarity_pin_oe; endproperty
  a_warm: assert property (p_warm) else $error("pin driven");
  property p_warm_off; $rose(reset_polarity_pin_i) |->
    ##4 !core_buck_warm_reset; endproperty
  a_warm_off: assert property (p_warm_off) else $error("warm held");
  property p_pp; second_general_output_o |->
    second_general_output_oe; endproperty
  a_pp: assert property (p_pp) else $error("high undriven");
endmodule
bind switch_cfg_bank switch_cfg_bank_asserts #(
  .PB_SHORT_CYC(PB_SHORT_CYC), .PG_DLY0_CYC(PG_DLY0_CYC))
  i_switch_cfg_bank_asserts (.ref_clk, .rst_b, .push_button_b,
  .power_good_raw, .reset_polarity_pin_i, .reset_polarity_pin_oe,
  .push_button_reset, .power_good, .strictness_bit_limits,
  .overvoltage_monitor_en, .core_buck_warm_reset,
  .second_general_output_o, .second_general_output_oe);
`default_nettype wire

// file: testbench/tb_top.sv
/* Self-checking bench for the switch and configuration bank.
   Assumes the host model and checker are compiled alongside. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, rst_b = 1'b0, seq_up = 1'b0;
  logic pb_b = 1'b1, pg_raw = 1'b0, rp_drv = 1'b1, fp_drv = 1'b1;
  logic scl, sda, sda_oe, rp_i, rp_oe, fp_i, fp_oe, so_o, so_oe;
  logic hv, fv, lv, gr, pbr, pg, st, ov, hys, warm, sdo, rpo, fpo;
  logic seq_lv = 1'b0, seq_gr = 1'b1;
  logic [1:0] hl, fl, ul;
  logic [7:0] q;
  int mismatches = 0, num_checks = 0;
  assign rp_i = rp_drv & ~rp_oe;  // Pulled-up pins
  assign fp_i = fp_drv & ~fp_oe;
  always #2 ref_clk = ~ref_clk;
  i2c_host i_i2c_host (.clk(ref_clk), .dev_oe(sda_oe), .scl, .sda);
  // Short timers: button 20/40, good delay 5..20 cycles
  switch_cfg_bank #(.PB_SHORT_CYC(32'h14), .PB_LONG_CYC(32'h28),
    .PG_DLY0_CYC(32'h5), .PG_DLY1_CYC(32'ha), .PG_DLY2_CYC(32'hf),
    .PG_DLY3_CYC(32'h14)) i_switch_cfg_bank (.ref_clk, .rst_b,
    .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe,
    .reset_polarity_pin_i(rp_i), .reset_polarity_pin_o(rpo),
    .reset_polarity_pin_oe(rp_oe), .first_general_pin_i(fp_i),
    .first_general_pin_o(fpo), .first_general_pin_oe(fp_oe),
    .second_general_output_o(so_o), .second_general_output_oe(so_oe),
    .seq_update(seq_up), .seq_low_voltage_switch_en(seq_lv),
    .seq_general_regulator_en(seq_gr), .push_button_b(pb_b),
    .power_good_raw(pg_raw), .high_voltage_switch_enable(hv),
    .five_volt_switch_enable(fv), .low_voltage_switch_enable(lv),
    .general_regulator_enable(gr), .push_button_reset(pbr),
    .power_good(pg), .strictness_bit_limits(st), .overvoltage_monitor_en(ov),
    .undervoltage_lockout_field(ul), .undervoltage_hysteresis(hys),
    .core_buck_warm_reset(warm), .high_voltage_switch_current_limit(hl),
    .five_volt_switch_current_limit(fl));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] sub, input logic [7:0] exp);
    i_i2c_host.rd(sub, q);
    chk(q, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial
  begin
    wt(90000);
    mismatches++;
    end_sim;
  end
  initial
  begin
    wt(4);
    rst_b <= 1'b1;
    wt(8);
    chk({rp_oe, fp_oe, so_oe, hv, fv, lv, gr, hys}, 8'he1);
    chk({5'h0, sdo, rpo, fpo}, 8'h00);
    rc(8'h12, 8'h00);
    rc(8'h13, 8'h08);
    rc(8'h14, 8'h40);
    i_i2c_host.wr(8'h12, 8'hff);
    rc(8'h12, 8'h00);
    i_i2c_host.wr(8'h10, 8'h33);
    rc(8'h10, 8'h00);
    $display("test reset and lock done");
    i_i2c_host.pwr(8'h12, 8'hbf);
    rc(8'h12, 8'h3f);
    chk({rp_oe, fp_oe, so_oe, hv, fv, lv, gr, hys}, 8'h9f);
    seq_up <= 1'b1;
    wt(1);
    seq_up <= 1'b0;
    wt(2);
    chk({6'h0, lv, gr}, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      i_i2c_host.pwr(8'h14, 8'(c * 5));
      chk({4'h0, hl, fl}, 8'(c * 5));
    end
    i_i2c_host.pwr(8'h14, 8'hff);
    rc(8'h14, 8'hcf);
    rp_drv <= 1'b0;
    wt(8);
    chk({6'h0, warm, rp_oe}, 8'h02);
    rp_drv <= 1'b1;
    wt(8);
    chk({7'h0, warm}, 8'h00);
    $display("test switches and limits done");
    // Each delay code: still low at the limit, high soon after
    for (int c = 0; c < 4; c++)
    begin
      i_i2c_host.pwr(8'h13, 8'(c * 9));
      chk({6'h0, ul}, 8'(c));
      pg_raw <= 1'b1;
      wt(5 * c + 5);
      chk({7'h0, pg}, 8'h00);
      wt(6);
      chk({7'h0, pg}, 8'h01);
      pg_raw <= 1'b0;
      wt(6);
      chk({7'h0, pg}, 8'h00);
    end
    for (int t = 0; t < 2; t++)
    begin
      i_i2c_host.pwr(8'h13, {t[0], 7'h64});
      pb_b <= 1'b0;
      wt(20 * t + 20);
      chk({7'h0, pbr}, 8'h00);
      wt(6);
      chk({7'h0, pbr}, 8'h01);
      pb_b <= 1'b1;
      wt(8);
    end
    chk({5'h0, st, ov, fp_oe}, 8'h06);
    chk({6'h0, so_o, so_oe}, 8'h03);
    fp_drv <= 1'b0;
    wt(8);
    chk({6'h0, so_o, so_oe}, 8'h01);
    $display("test supervisor setup done");
    end_sim;
  end
endmodule
`default_nettype wire
